/* File: rtl/ccr_core_regs.sv */
/*
  Programmer-visible core registers: accumulator, two index registers,
  program counter, stack pointer and the condition flags, plus pending
  interrupt latches, vector selection and the context sequencer.
  Assumes the decoder drives one operation per enabled cycle on cmd_in
  while busy_out is low, and that the stack memory answers pops with
  data on stack_rdata_in in the cycle the read strobe is shown.
*/
// Behaviour
// - Eight-bit accumulator holds operands and results
// - Two eight-bit index registers for addressing
// - Second index register never saved on interrupts
// - Sixteen-bit program counter from two bytes
// - Flag layout fixed; top three, half and mask reset one
// - Half carry from bit three on adds
// - Mask set on entry, software sets clears
// - Mask blocks maskable sources, never the trap
// - Masked requests latched pending until unmasked
// - Clearing mask inside routine services pending now
// - Return from interrupt clears the mask
// - Negative equals result bit seven
// - Zero set when result is zero
// - Carry reflects last arithmetic overflow
// - Set and reset carry instructions force carry
// - Bit test, shift, rotate update carry
// - Flags pushed and popped via stack
// - Timer overflow uses its fixed vector
// - Compare and capture use own vectors
// - External rising request edges use own vectors
// - End of suspend has separate vector
// - Interrupt frame five bytes, low PC first
// - Stack pointer resets to 01ff, high forced
module ccr_core_regs (
  input  wire logic                  mclk_in,
  input  wire logic                  rst_b_in,
  input  wire logic                  clk_en_in,
  input  wire ccr_pkg::ccr_cmd_t     cmd_in,
  input  wire logic [9:0]            irq_req_in,
  input  wire logic [7:0]            stack_rdata_in,
  output logic [7:0]                 acc_out,
  output logic [7:0]                 index_x_out,
  output logic [7:0]                 index_y_out,
  output logic [15:0]                pc_out,
  output logic [15:0]                sp_out,
  output logic [7:0]                 condition_flags_out,
  output logic [9:0]                 pending_out,
  output logic                       vec_valid_out,
  output logic [15:0]                vec_addr_out,
  output logic                       busy_out,
  output ccr_pkg::ccr_stack_t        stack_out
);

  // Register state
  logic [7:0]          acc;                 // Accumulator
  logic [7:0]          index_x;             // First index register
  logic [7:0]          index_y;             // Second index register
  logic [7:0]          program_counter_low; // PC low byte
  logic [7:0]          program_counter_high;// PC high byte
  logic [7:0]          stack_pointer;       // Low byte of stack pointer
  logic [7:0]          condition_flags;     // Flags byte
  logic [9:0]          pending;             // Latched requests
  logic [9:0]          req_q;               // Previous request levels
  ccr_pkg::ccr_state_t state;               // Context sequencer
  logic [2:0]          step;                // Byte index in frame
  logic [2:0]          frame_len;           // Bytes in current frame
  logic                frame_irq;           // Frame belongs to interrupt
  logic                frame_cc;            // Single flags byte pop
  ccr_pkg::ccr_stack_t stack_q;             // Registered stack strobe
  logic                vec_valid;           // Vector request pulse
  logic [15:0]         vec_addr;            // Vector being fetched

  // Combinational helpers
  logic [8:0]  sum;          // Full add result
  logic [4:0]  half_sum;     // Low nibble add
  logic [7:0]  result;       // Result seen by N and Z
  logic        run;          // Decoder may issue
  logic        take_irq;     // Start servicing a maskable source
  logic [3:0]  win_idx;      // Winning source index
  logic [15:0] win_vec;      // Its vector
  logic [9:0]  rise;         // New request edges
  logic [7:0]  push_byte;    // Byte pushed at current step

  // Arithmetic on the two operands
  // nibble carry path
  assign half_sum = {1'b0, cmd_in.a[3:0]} + {1'b0, cmd_in.b[3:0]}
                  + {4'h0, cmd_in.cin};
  assign sum      = {1'b0, cmd_in.a} + {1'b0, cmd_in.b} + {8'h00, cmd_in.cin};
  assign result   = (cmd_in.op == ccr_pkg::CCR_OP_ADD) ? sum[7:0] : cmd_in.a;
  assign run      = clk_en_in && (state == ccr_pkg::CCR_ST_RUN);

  // Lowest index wins among pending sources
  always_comb begin
    win_idx = 4'h0;
    win_vec = ccr_pkg::VEC_USB;
    for (int i = ccr_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (pending[i]) begin
        win_idx = 4'(i);
      end
    end
    case (win_idx)
      4'h0:    win_vec = ccr_pkg::VEC_USB;
      4'h1:    win_vec = ccr_pkg::VEC_I2C;
      4'h2:    win_vec = ccr_pkg::VEC_TOVF;
      4'h3:    win_vec = ccr_pkg::VEC_TCMP;
      4'h4:    win_vec = ccr_pkg::VEC_TCAP;
      4'h5:    win_vec = ccr_pkg::VEC_EXT1;
      4'h6:    win_vec = ccr_pkg::VEC_EXT2;
      4'h7:    win_vec = ccr_pkg::VEC_DDC;
      4'h8:    win_vec = ccr_pkg::VEC_DDCCI;
      default: win_vec = ccr_pkg::VEC_ESUSP;
    endcase
  end

  assign take_irq = run && (|pending)
                  && !condition_flags[ccr_pkg::FLAG_MASK]
                  && (cmd_in.op == ccr_pkg::CCR_OP_NONE);

  // Edge of each request level
  assign rise = irq_req_in & ~req_q;

  // low PC first, then high, X, A, flags
  // second index register not in the frame
  always_comb begin
    case (step)
      3'h0:    push_byte = program_counter_low;
      3'h1:    push_byte = program_counter_high;
      3'h2:    push_byte = index_x;
      3'h3:    push_byte = acc;
      default: push_byte = condition_flags;
    endcase
  end

  // Request edge history
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      req_q <= 10'h000;
    end else if (clk_en_in) begin
      req_q <= irq_req_in;
    end
  end

  // pending latch; a new edge wins over service clear
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pending <= 10'h000;
    end else if (clk_en_in) begin
      for (int i = 0; i < ccr_pkg::NUM_SRC; i++) begin
        if (rise[i]) begin
          pending[i] <= 1'b1;
        end else if (take_irq && (win_idx == 4'(i))) begin
          pending[i] <= 1'b0;
        end
      end
    end
  end

  // Data registers written by loads, adds and frame pops
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      acc     <= ccr_pkg::BYTE_ZERO;
      index_x <= ccr_pkg::BYTE_ZERO;
      index_y <= ccr_pkg::BYTE_ZERO;
    end else if (clk_en_in) begin
      if (run && cmd_in.op == ccr_pkg::CCR_OP_LOAD) begin
        case (cmd_in.dst)
          ccr_pkg::CCR_DST_ACC: acc     <= cmd_in.a;
          ccr_pkg::CCR_DST_X:   index_x <= cmd_in.a;
          ccr_pkg::CCR_DST_Y:   index_y <= cmd_in.a;
          default:              ;
        endcase
      end else if (run && cmd_in.op == ccr_pkg::CCR_OP_ADD) begin
        acc <= sum[7:0];
      end else if (state == ccr_pkg::CCR_ST_POP && frame_irq) begin
        // Pop order is flags, A, X, PROGRAM_COUNTER_HIGH, PROGRAM_COUNTER_LOW; Y untouched
        case (step)
          3'h1: acc     <= stack_rdata_in;
          3'h2: index_x <= stack_rdata_in;
          default: ;
        endcase
      end
    end
  end

  // Program counter bytes
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      program_counter_low  <= ccr_pkg::PC_RESET[7:0];
      program_counter_high <= ccr_pkg::PC_RESET[15:8];
    end else if (clk_en_in) begin
      if (run && cmd_in.op == ccr_pkg::CCR_OP_LOAD
          && cmd_in.dst == ccr_pkg::CCR_DST_PCL) begin
        program_counter_low <= cmd_in.a;
      end else if (run && cmd_in.op == ccr_pkg::CCR_OP_LOAD
                   && cmd_in.dst == ccr_pkg::CCR_DST_PCH) begin
        program_counter_high <= cmd_in.a;
      end else if (state == ccr_pkg::CCR_ST_POP && !frame_cc) begin
        if (step == frame_len - 3'h1) begin
          program_counter_low <= stack_rdata_in;
        end else if (step == frame_len - 3'h2) begin
          program_counter_high <= stack_rdata_in;
        end
      end
    end
  end

  // Condition flags
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      // reset with top bits and mask at one
      condition_flags <= ccr_pkg::FLAGS_RESET;
    end else if (clk_en_in) begin
      if (take_irq || (run && cmd_in.op == ccr_pkg::CCR_OP_TRAP)) begin
        condition_flags[ccr_pkg::FLAG_MASK] <= 1'b1;
      end else if (state == ccr_pkg::CCR_ST_POP && step == 3'h0
                   && frame_irq) begin
        condition_flags <= ccr_pkg::FLAGS_ONES
                         | (stack_rdata_in & 8'h17);
      end else if (state == ccr_pkg::CCR_ST_POP && frame_cc) begin
        // flags popped as stored, mask included
        condition_flags <= ccr_pkg::FLAGS_ONES
                         | (stack_rdata_in & 8'h1f);
      end else if (run) begin
        case (cmd_in.op)
          ccr_pkg::CCR_OP_ADD: begin
            // half carry and carry from sum
            condition_flags[ccr_pkg::FLAG_HALF]  <= half_sum[4];
            condition_flags[ccr_pkg::FLAG_CARRY] <= sum[8];
            condition_flags[ccr_pkg::FLAG_NEG]   <= result[7];
            condition_flags[ccr_pkg::FLAG_ZERO]  <= (result == 8'h00);
          end
          ccr_pkg::CCR_OP_LOGIC: begin
            condition_flags[ccr_pkg::FLAG_NEG]  <= result[7];
            condition_flags[ccr_pkg::FLAG_ZERO] <= (result == 8'h00);
          end
          ccr_pkg::CCR_OP_SHIFT: begin
            condition_flags[ccr_pkg::FLAG_CARRY] <= cmd_in.cout;
            condition_flags[ccr_pkg::FLAG_NEG]   <= result[7];
            condition_flags[ccr_pkg::FLAG_ZERO]  <= (result == 8'h00);
          end
          ccr_pkg::CCR_OP_BTJ:
            condition_flags[ccr_pkg::FLAG_CARRY] <= cmd_in.cout;
          ccr_pkg::CCR_OP_SCF:
            condition_flags[ccr_pkg::FLAG_CARRY] <= 1'b1;
          ccr_pkg::CCR_OP_RCF:
            condition_flags[ccr_pkg::FLAG_CARRY] <= 1'b0;
          ccr_pkg::CCR_OP_SIM:
            condition_flags[ccr_pkg::FLAG_MASK] <= 1'b1;
          ccr_pkg::CCR_OP_RIM:
            condition_flags[ccr_pkg::FLAG_MASK] <= 1'b0;
          default: ;
        endcase
      end
    end
  end

  // Context sequencer and stack pointer
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state         <= ccr_pkg::CCR_ST_RUN;
      step          <= 3'h0;
      frame_len     <= 3'h0;
      frame_irq     <= 1'b0;
      frame_cc      <= 1'b0;
      stack_pointer <= ccr_pkg::SP_RESET[7:0];
      stack_q       <= '0;
    end else if (clk_en_in) begin
      stack_q.wr <= 1'b0;
      stack_q.rd <= 1'b0;
      case (state)
        ccr_pkg::CCR_ST_RUN: begin
          step     <= 3'h0;
          frame_cc <= 1'b0;
          if (take_irq || cmd_in.op == ccr_pkg::CCR_OP_TRAP) begin
            state     <= ccr_pkg::CCR_ST_PUSH;
            frame_len <= ccr_pkg::IRQ_FRAME;
            frame_irq <= 1'b1;
          end else if (cmd_in.op == ccr_pkg::CCR_OP_CALL) begin
            state     <= ccr_pkg::CCR_ST_PUSH;
            frame_len <= ccr_pkg::CALL_FRAME;
            frame_irq <= 1'b0;
          end else if (cmd_in.op == ccr_pkg::CCR_OP_RETURN_FROM_INTERRUPT ||
                       cmd_in.op == ccr_pkg::CCR_OP_RET) begin
            state     <= ccr_pkg::CCR_ST_POP;
            frame_len <= (cmd_in.op == ccr_pkg::CCR_OP_RETURN_FROM_INTERRUPT)
                       ? ccr_pkg::IRQ_FRAME : ccr_pkg::CALL_FRAME;
            frame_irq <= (cmd_in.op == ccr_pkg::CCR_OP_RETURN_FROM_INTERRUPT);
            stack_pointer <= stack_pointer + 8'h01;
            stack_q.rd    <= 1'b1;
            stack_q.addr  <= {ccr_pkg::SP_HIGH, stack_pointer + 8'h01};
          end else if (cmd_in.op == ccr_pkg::CCR_OP_PUSHCC) begin
            stack_q.wr    <= 1'b1;
            stack_q.addr  <= {ccr_pkg::SP_HIGH, stack_pointer};
            stack_q.data  <= condition_flags;
            stack_pointer <= stack_pointer - 8'h01;
          end else if (cmd_in.op == ccr_pkg::CCR_OP_POPCC) begin
            // flags back from stack, one byte
            state         <= ccr_pkg::CCR_ST_POP;
            frame_len     <= 3'h1;
            frame_irq     <= 1'b0;
            frame_cc      <= 1'b1;
            stack_pointer <= stack_pointer + 8'h01;
            stack_q.rd    <= 1'b1;
            stack_q.addr  <= {ccr_pkg::SP_HIGH, stack_pointer + 8'h01};
          end else if (cmd_in.op == ccr_pkg::CCR_OP_LOAD &&
                       cmd_in.dst == ccr_pkg::CCR_DST_SP) begin
            stack_pointer <= cmd_in.a;
          end
        end
        ccr_pkg::CCR_ST_PUSH: begin
          // one byte per cycle, SP down after each
          stack_q.wr    <= 1'b1;
          stack_q.addr  <= {ccr_pkg::SP_HIGH, stack_pointer};
          stack_q.data  <= push_byte;
          stack_pointer <= stack_pointer - 8'h01;
          step          <= step + 3'h1;
          if (step == frame_len - 3'h1) begin
            state <= ccr_pkg::CCR_ST_RUN;
          end
        end
        ccr_pkg::CCR_ST_POP: begin
          step <= step + 3'h1;
          if (step == frame_len - 3'h1) begin
            state <= ccr_pkg::CCR_ST_RUN;
          end else begin
            stack_pointer <= stack_pointer + 8'h01;
            stack_q.rd    <= 1'b1;
            stack_q.addr  <= {ccr_pkg::SP_HIGH, stack_pointer + 8'h01};
          end
        end
        default: state <= ccr_pkg::CCR_ST_RUN;
      endcase
    end
  end

  // Vector fetch request, high byte address
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      vec_valid <= 1'b1;
      vec_addr  <= ccr_pkg::VEC_RESET;
    end else if (clk_en_in) begin
      vec_valid <= 1'b0;
      if (take_irq) begin
        vec_valid <= 1'b1;
        vec_addr  <= win_vec;
      end else if (run && cmd_in.op == ccr_pkg::CCR_OP_TRAP) begin
        vec_valid <= 1'b1;
        vec_addr  <= ccr_pkg::VEC_TRAP;
      end
    end
  end

  // Outputs straight from flip-flops, busy_out decoded from state
  assign acc_out             = acc;
  assign index_x_out         = index_x;
  assign index_y_out         = index_y;
  assign pc_out              = {program_counter_high, program_counter_low};
  assign sp_out              = {ccr_pkg::SP_HIGH, stack_pointer};
  assign condition_flags_out = condition_flags;
  assign pending_out         = pending;
  assign vec_valid_out       = vec_valid;
  assign vec_addr_out        = vec_addr;
  assign busy_out            = (state != ccr_pkg::CCR_ST_RUN);
  assign stack_out           = stack_q;

  // Checks
  property p_flag_top;
    @(posedge mclk_in) disable iff (!rst_b_in)
      condition_flags[7:5] == 3'b111;
  endproperty
  a_flag_top: assert property (p_flag_top)
    else $error("flag top bits not one");

  property p_trap_vec;
    @(posedge mclk_in) disable iff (!rst_b_in)
      (run && cmd_in.op == ccr_pkg::CCR_OP_TRAP && !take_irq)
      |=> vec_valid && vec_addr == ccr_pkg::VEC_TRAP;
  endproperty
  a_trap_vec: assert property (p_trap_vec)
    else $error("trap did not vector");

  property p_mask_entry;
    @(posedge mclk_in) disable iff (!rst_b_in)
      take_irq |=> condition_flags[ccr_pkg::FLAG_MASK];
  endproperty
  a_mask_entry: assert property (p_mask_entry)
    else $error("mask not set on entry");

  property p_masked_hold;
    @(posedge mclk_in) disable iff (!rst_b_in)
      condition_flags[ccr_pkg::FLAG_MASK] |-> !take_irq;
  endproperty
  a_masked_hold: assert property (p_masked_hold)
    else $error("masked source serviced");

  property p_add_carry;
    @(posedge mclk_in) disable iff (!rst_b_in)
      (run && cmd_in.op == ccr_pkg::CCR_OP_ADD && !take_irq)
      |=> condition_flags[ccr_pkg::FLAG_CARRY] == $past(sum[8])
       && condition_flags[ccr_pkg::FLAG_HALF] == $past(half_sum[4]);
  endproperty
  a_add_carry: assert property (p_add_carry)
    else $error("add carries wrong");

  property p_zero_neg;
    @(posedge mclk_in) disable iff (!rst_b_in)
      (run && cmd_in.op == ccr_pkg::CCR_OP_LOGIC && !take_irq)
      |=> condition_flags[ccr_pkg::FLAG_ZERO] == ($past(cmd_in.a) == 8'h00)
       && condition_flags[ccr_pkg::FLAG_NEG] == $past(cmd_in.a[7]);
  endproperty
  a_zero_neg: assert property (p_zero_neg)
    else $error("zero or negative wrong");

  property p_frame_len;
    @(posedge mclk_in) disable iff (!rst_b_in)
      (clk_en_in && take_irq) ##1 clk_en_in [*5]
      |=> state == ccr_pkg::CCR_ST_RUN;
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("frame not five bytes");

  property p_y_kept;
    @(posedge mclk_in) disable iff (!rst_b_in)
      (state != ccr_pkg::CCR_ST_RUN) |=> index_y == $past(index_y);
  endproperty
  a_y_kept: assert property (p_y_kept)
    else $error("second index changed by context");

  property p_sp_high;
    @(posedge mclk_in) disable iff (!rst_b_in)
      sp_out[15:8] == ccr_pkg::SP_HIGH;
  endproperty
  a_sp_high: assert property (p_sp_high)
    else $error("stack high byte not forced");

  c_irq: cover property (@(posedge mclk_in) disable iff (!rst_b_in)
    take_irq);
  c_trap: cover property (@(posedge mclk_in) disable iff (!rst_b_in)
    run && cmd_in.op == ccr_pkg::CCR_OP_TRAP);
  c_return_from_interrupt: cover property (@(posedge mclk_in) disable iff (!rst_b_in)
    state == ccr_pkg::CCR_ST_POP && frame_irq && step == 3'h4);

endmodule : ccr_core_regs

/* File: rtl/ccr_pkg.sv */
/*
  Package for the core register file: widths, flag positions, reset values,
  operation codes, vector addresses and the state of the context sequencer.
  Assumes a single clock domain and a core decoder that drives the op port.
*/
package ccr_pkg;

  // Flag positions in the condition flags byte
  localparam int unsigned FLAG_CARRY = 0;
  localparam int unsigned FLAG_ZERO  = 1;
  localparam int unsigned FLAG_NEG   = 2;
  localparam int unsigned FLAG_MASK  = 3;
  localparam int unsigned FLAG_HALF  = 4;

  // Values after reset
  localparam logic [7:0]  FLAGS_RESET = 8'hf8;
  localparam logic [7:0]  FLAGS_ONES  = 8'he0;
  localparam logic [15:0] SP_RESET    = 16'h01ff;
  localparam logic [7:0]  SP_HIGH     = 8'h01;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;
  localparam logic [15:0] PC_RESET    = 16'h0000;

  // Stack bytes per context kind
  localparam logic [2:0] IRQ_FRAME   = 3'h5;
  localparam logic [2:0] CALL_FRAME  = 3'h2;

  // Interrupt sources, one bit each
  localparam int unsigned NUM_SRC   = 10;
  localparam int unsigned SRC_USB   = 0;
  localparam int unsigned SRC_I2C   = 1;
  localparam int unsigned SRC_TOVF  = 2;
  localparam int unsigned SRC_TCMP  = 3;
  localparam int unsigned SRC_TCAP  = 4;
  localparam int unsigned SRC_EXT1  = 5;
  localparam int unsigned SRC_EXT2  = 6;
  localparam int unsigned SRC_DDC   = 7;
  localparam int unsigned SRC_DDCCI = 8;
  localparam int unsigned SRC_ESUSP = 9;

  // Vector high-byte addresses; low byte sits one above
  localparam logic [15:0] VEC_USB   = 16'hffe6;
  localparam logic [15:0] VEC_I2C   = 16'hffea;
  localparam logic [15:0] VEC_TOVF  = 16'hffec;
  localparam logic [15:0] VEC_TCMP  = 16'hffee;
  localparam logic [15:0] VEC_TCAP  = 16'hfff0;
  localparam logic [15:0] VEC_EXT1  = 16'hfff2;
  localparam logic [15:0] VEC_EXT2  = 16'hfff4;
  localparam logic [15:0] VEC_DDC   = 16'hfff6;
  localparam logic [15:0] VEC_DDCCI = 16'hfff8;
  localparam logic [15:0] VEC_ESUSP = 16'hfffa;
  localparam logic [15:0] VEC_TRAP  = 16'hfffc;
  localparam logic [15:0] VEC_RESET = 16'hfffe;

  // Operations issued by the decoder
  typedef enum logic [3:0] {
    CCR_OP_NONE    = 4'h0,
    CCR_OP_ADD     = 4'h1,
    CCR_OP_LOGIC   = 4'h2,
    CCR_OP_SHIFT   = 4'h3,
    CCR_OP_BTJ     = 4'h4,
    CCR_OP_SCF     = 4'h5,
    CCR_OP_RCF     = 4'h6,
    CCR_OP_SIM     = 4'h7,
    CCR_OP_RIM     = 4'h8,
    CCR_OP_RETURN_FROM_INTERRUPT    = 4'h9,
    CCR_OP_PUSHCC  = 4'ha,
    CCR_OP_POPCC   = 4'hb,
    CCR_OP_TRAP    = 4'hc,
    CCR_OP_CALL    = 4'hd,
    CCR_OP_RET     = 4'he,
    CCR_OP_LOAD    = 4'hf
  } ccr_op_t;

  // Register selector for loads
  typedef enum logic [2:0] {
    CCR_DST_ACC = 3'h0,
    CCR_DST_X   = 3'h1,
    CCR_DST_Y   = 3'h2,
    CCR_DST_PCL = 3'h3,
    CCR_DST_PCH = 3'h4,
    CCR_DST_SP  = 3'h5
  } ccr_dst_t;

  // One-hot sequencer state
  typedef enum logic [2:0] {
    CCR_ST_RUN  = 3'b001,
    CCR_ST_PUSH = 3'b010,
    CCR_ST_POP  = 3'b100
  } ccr_state_t;

  // Decoder command carried as one bundle
  typedef struct packed {
    ccr_op_t    op;
    ccr_dst_t   dst;
    logic [7:0] a;
    logic [7:0] b;
    logic       cin;
    logic       cout;
  } ccr_cmd_t;

  // Stack write and read strobes with address and data
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  data;
  } ccr_stack_t;

endpackage : ccr_pkg

/* File: tb/test_cpu_core_registers_and_flags.sv */
/*
  Self-checking bench for the core register file: flags, loads, vectors.
  Assumes the design checks its own timing with internal assertions.
*/
module test_cpu_core_registers_and_flags;
  timeunit 1ns;
  timeprecision 1ps;
  logic                mclk_in, rst_b_in, clk_en_in, vec_valid, busy;
  ccr_pkg::ccr_cmd_t   cmd_in;
  ccr_pkg::ccr_stack_t stk;
  logic [9:0]          irq_req_in, pending;
  logic [7:0]          rdata, acc, ix, iy, flags;
  logic [15:0]         pc, sp, vec, first_wr;
  int                  fail_count, cmp_count, nwr;
  int                  src[6] = '{2, 3, 4, 5, 6, 9};
  logic [15:0]         exp_vec[6] = '{16'hffec, 16'hffee, 16'hfff0,
                                      16'hfff2, 16'hfff4, 16'hfffa};

  ccr_core_regs i_dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
    .clk_en_in(clk_en_in), .cmd_in(cmd_in), .irq_req_in(irq_req_in),
    .stack_rdata_in(rdata), .acc_out(acc), .index_x_out(ix),
    .index_y_out(iy), .pc_out(pc), .sp_out(sp),
    .condition_flags_out(flags), .pending_out(pending),
    .vec_valid_out(vec_valid), .vec_addr_out(vec), .busy_out(busy),
    .stack_out(stk));

  // Clock at 20 MHz
  initial begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end

  // Compare one value and count it
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    cmp_count++;
    if (seen !== want) begin
      fail_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check

  // Step n rising edges, to just after the last of them
  task automatic cyc(input int n);
    repeat (n) begin
      @(posedge mclk_in);
      #1;
    end
  endtask : cyc

  // Present one decoder operation for one cycle
  task automatic op(input ccr_pkg::ccr_op_t o, input ccr_pkg::ccr_dst_t d,
                    input logic [7:0] a, input logic [7:0] b, input logic co);
    cmd_in = '{o, d, a, b, 1'b0, co};
    cyc(1);
  endtask : op

  // Wait for a vector fetch, then watch the frame being pushed
  task automatic wait_vec(input logic [15:0] want);
    cmd_in.op = ccr_pkg::CCR_OP_NONE;
    for (int i = 0; i < 20; i++) begin
      if (vec_valid === 1'b1) begin
        check(vec, want);
        check(16'(flags[ccr_pkg::FLAG_MASK]), 16'h1);
        nwr = 0;
        first_wr = 16'h0;
        for (int k = 0; k < 6; k++) begin
          cyc(1);
          if (stk.wr === 1'b1 && nwr++ == 0) first_wr = stk.addr;
        end
        check(16'(nwr), 16'h5);
        check(first_wr, 16'h01ff);
        return;
      end
      cyc(1);
    end
    fail_count++;
    test_done();
  endtask : wait_vec

  // Leave the routine and confirm the mask clears and second index survives
  task automatic leave;
    irq_req_in = 10'h0;
    op(ccr_pkg::CCR_OP_RETURN_FROM_INTERRUPT, ccr_pkg::CCR_DST_ACC, 8'h00, 8'h00, 1'b0);
    cmd_in.op = ccr_pkg::CCR_OP_NONE;
    cyc(7);
    check(16'(flags), 16'h00e0);
    check(16'(iy), 16'h005a);
    check(sp, 16'h01ff);
  endtask : leave

  // Print counts and the verdict, then stop
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done

  // Main sequence
  initial begin
    fail_count = 0;
    cmp_count = 0;
    rst_b_in = 1'b0;
    clk_en_in = 1'b1;
    cmd_in = '0;
    irq_req_in = 10'h0;
    rdata = 8'h00;
    cyc(2);
    check(16'(flags), 16'h00f8);
    check(sp, 16'h01ff);
    check(vec, 16'hfffe);
    check(pc, 16'h0000);
    rst_b_in = 1'b1;
    op(ccr_pkg::CCR_OP_LOAD, ccr_pkg::CCR_DST_Y, 8'h5a, 8'h00, 1'b0);
    op(ccr_pkg::CCR_OP_LOAD, ccr_pkg::CCR_DST_X, 8'ha5, 8'h00, 1'b0);
    check(16'(iy), 16'h005a);
    check(16'(ix), 16'h00a5);
    op(ccr_pkg::CCR_OP_ADD, ccr_pkg::CCR_DST_ACC, 8'h0f, 8'h01, 1'b0);
    check(16'(acc), 16'h0010);
    check(16'(flags), 16'h00f8);
    op(ccr_pkg::CCR_OP_ADD, ccr_pkg::CCR_DST_ACC, 8'h80, 8'h80, 1'b0);
    check(16'(flags), 16'h00eb);
    op(ccr_pkg::CCR_OP_RCF, ccr_pkg::CCR_DST_ACC, 8'h00, 8'h00, 1'b0);
    check(16'(flags), 16'h00ea);
    op(ccr_pkg::CCR_OP_SCF, ccr_pkg::CCR_DST_ACC, 8'h00, 8'h00, 1'b0);
    check(16'(flags), 16'h00eb);
    op(ccr_pkg::CCR_OP_SHIFT, ccr_pkg::CCR_DST_ACC, 8'h80, 8'h00, 1'b0);
    check(16'(flags), 16'h00ec);
    op(ccr_pkg::CCR_OP_RIM, ccr_pkg::CCR_DST_ACC, 8'h00, 8'h00, 1'b0);
    check(16'(flags), 16'h00e4);
    op(ccr_pkg::CCR_OP_LOGIC, ccr_pkg::CCR_DST_ACC, 8'h00, 8'h00, 1'b0);
    check(16'(flags), 16'h00e2);
    op(ccr_pkg::CCR_OP_PUSHCC, ccr_pkg::CCR_DST_ACC, 8'h00, 8'h00, 1'b0);
    check(16'(stk.data), 16'h00e2);
    check(stk.addr, 16'h01ff);
    check(sp, 16'h01fe);
    rdata = 8'h15;
    op(ccr_pkg::CCR_OP_POPCC, ccr_pkg::CCR_DST_ACC, 8'h00, 8'h00, 1'b0);
    cmd_in.op = ccr_pkg::CCR_OP_NONE;
    cyc(1);
    rdata = 8'h00;
    check(16'(flags), 16'h00f5);
    check(sp, 16'h01ff);
    op(ccr_pkg::CCR_OP_BTJ, ccr_pkg::CCR_DST_ACC, 8'h00, 8'h00, 1'b0);
    check(16'(flags), 16'h00f4);
    op(ccr_pkg::CCR_OP_LOAD, ccr_pkg::CCR_DST_PCL, 8'h34, 8'h00, 1'b0);
    op(ccr_pkg::CCR_OP_LOAD, ccr_pkg::CCR_DST_PCH, 8'h12, 8'h00, 1'b0);
    check(pc, 16'h1234);
    // Each timer, external and end-of-suspend source in turn
    for (int s = 0; s < 6; s++) begin
      irq_req_in[src[s]] = 1'b1;
      wait_vec(exp_vec[s]);
      leave();
    end
    // Masked request waits pending until the mask clears
    op(ccr_pkg::CCR_OP_SIM, ccr_pkg::CCR_DST_ACC, 8'h00, 8'h00, 1'b0);
    irq_req_in[7] = 1'b1;
    cmd_in.op = ccr_pkg::CCR_OP_NONE;
    cyc(4);
    check(16'(pending[7]), 16'h1);
    check(16'(vec_valid), 16'h0);
    op(ccr_pkg::CCR_OP_RIM, ccr_pkg::CCR_DST_ACC, 8'h00, 8'h00, 1'b0);
    wait_vec(16'hfff6);
    leave();
    // Trap gets through a set mask
    op(ccr_pkg::CCR_OP_SIM, ccr_pkg::CCR_DST_ACC, 8'h00, 8'h00, 1'b0);
    op(ccr_pkg::CCR_OP_TRAP, ccr_pkg::CCR_DST_ACC, 8'h00, 8'h00, 1'b0);
    wait_vec(16'hfffc);
    test_done();
  end
endmodule : test_cpu_core_registers_and_flags
